//--- design/duc_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the control block registers
// Assumes: One write and one read outstanding at most
// Notes: Writes use only byte lane 0, status reads also use lanes 1 and 2; unmapped addresses get SLVERR
`timescale 1ns/10ps
module duc_axil_slave (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Write address and data
   input wire logic s_axil_awvalid_i,
   output logic s_axil_awready_o,
   input wire logic [duc_pkg::AXI_AW-1:0] s_axil_awaddr_i,
   input wire logic s_axil_wvalid_i,
   output logic s_axil_wready_o,
   input wire logic [duc_pkg::AXI_DW-1:0] s_axil_wdata_i,
   input wire logic [3:0] s_axil_wstrb_i,
   // Write response
   output logic s_axil_bvalid_o,
   input wire logic s_axil_bready_i,
   output logic [1:0] s_axil_bresp_o,
   // Read address and data
   input wire logic s_axil_arvalid_i,
   output logic s_axil_arready_o,
   input wire logic [duc_pkg::AXI_AW-1:0] s_axil_araddr_i,
   output logic s_axil_rvalid_o,
   input wire logic s_axil_rready_i,
   output logic [duc_pkg::AXI_DW-1:0] s_axil_rdata_o,
   output logic [1:0] s_axil_rresp_o,
   // Register file side
   output logic wr_en_o,
   output logic [duc_pkg::AXI_AW-1:0] wr_addr_o,
   output logic [duc_pkg::BYTE_W-1:0] wr_data_o,
   input wire logic wr_hit_i,
   output logic [duc_pkg::AXI_AW-1:0] rd_addr_o,
   input wire logic [duc_pkg::AXI_DW-1:0] rd_data_i,
   input wire logic rd_hit_i
);
   import duc_pkg::*;

   logic aw_rdy_r, aw_rdy_nxt, w_rdy_r, w_rdy_nxt;
   logic [AXI_AW-1:0] awaddr_r, awaddr_nxt;
   logic [BYTE_W-1:0] wdata_r, wdata_nxt;
   logic wlane_r, wlane_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic ar_rdy_r, ar_rdy_nxt, rvalid_r, rvalid_nxt;
   logic [AXI_DW-1:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic fire;

   // Both halves held and no response pending
   assign fire = !aw_rdy_r && !w_rdy_r && !bvalid_r;
   assign wr_en_o = fire && wlane_r && wr_hit_i;
   assign wr_addr_o = awaddr_r;
   assign wr_data_o = wdata_r;
   assign rd_addr_o = s_axil_araddr_i;

   always_comb begin
      aw_rdy_nxt = aw_rdy_r;
      w_rdy_nxt = w_rdy_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wlane_nxt = wlane_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      ar_rdy_nxt = ar_rdy_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (aw_rdy_r && s_axil_awvalid_i) begin
         aw_rdy_nxt = 1'b0;
         awaddr_nxt = s_axil_awaddr_i;
      end
      if (w_rdy_r && s_axil_wvalid_i) begin
         w_rdy_nxt = 1'b0;
         wdata_nxt = s_axil_wdata_i[BYTE_W-1:0];
         wlane_nxt = s_axil_wstrb_i[0];
      end
      if (fire) begin
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_hit_i ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && s_axil_bready_i) begin
         bvalid_nxt = 1'b0;
         aw_rdy_nxt = 1'b1;
         w_rdy_nxt = 1'b1;
      end
      if (ar_rdy_r && s_axil_arvalid_i) begin
         ar_rdy_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_hit_i ? rd_data_i : WORD_ZERO;
         rresp_nxt = rd_hit_i ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_r && s_axil_rready_i) begin
         rvalid_nxt = 1'b0;
         ar_rdy_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aw_rdy_r <= 1'b1;
         w_rdy_r <= 1'b1;
         awaddr_r <= '0;
         wdata_r <= BYTE_RST;
         wlane_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         ar_rdy_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= WORD_ZERO;
         rresp_r <= RESP_OKAY;
      end else begin
         aw_rdy_r <= aw_rdy_nxt;
         w_rdy_r <= w_rdy_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wlane_r <= wlane_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         ar_rdy_r <= ar_rdy_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axil_awready_o = aw_rdy_r;
   assign s_axil_wready_o = w_rdy_r;
   assign s_axil_bvalid_o = bvalid_r;
   assign s_axil_bresp_o = bresp_r;
   assign s_axil_arready_o = ar_rdy_r;
   assign s_axil_rvalid_o = rvalid_r;
   assign s_axil_rdata_o = rdata_r;
   assign s_axil_rresp_o = rresp_r;

endmodule : duc_axil_slave

//--- design/duc_top.sv
// Purpose: Update and trigger control for a 10-bit digital-to-analog converter
// Assumes: Peripheral flags are raw, on the system clock, set before any mask
// Notes: Shadow value only changes on a high byte write or a qualifying trigger
//
// What this block does
// - Enabled converter converts staged value per control
// - Auto triggering only while auto-trigger bit set
// - Trigger source taken from select field
// - Rising trigger edge loads and converts value
// - Trigger still high at finish: no restart
// - Edges during a conversion are ignored
// - Trigger follows raw flag, not interrupt enable
// - Manual mode: high byte write updates immediately
// - Control register field layout, resets to zero
// - Converter input value is 10 bits
// - Select encodes eight fixed trigger sources
// - Left adjust mapping, applied on high write
// - Low byte staged until high write or trigger
// - Output enable routes result to pin
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module duc_top (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // AXI4-Lite write channels
   input wire logic s_axil_awvalid_i,
   output logic s_axil_awready_o,
   input wire logic [duc_pkg::AXI_AW-1:0] s_axil_awaddr_i,
   input wire logic s_axil_wvalid_i,
   output logic s_axil_wready_o,
   input wire logic [duc_pkg::AXI_DW-1:0] s_axil_wdata_i,
   input wire logic [3:0] s_axil_wstrb_i,
   output logic s_axil_bvalid_o,
   input wire logic s_axil_bready_i,
   output logic [1:0] s_axil_bresp_o,
   // AXI4-Lite read channels
   input wire logic s_axil_arvalid_i,
   output logic s_axil_arready_o,
   input wire logic [duc_pkg::AXI_AW-1:0] s_axil_araddr_i,
   output logic s_axil_rvalid_o,
   input wire logic s_axil_rready_i,
   output logic [duc_pkg::AXI_DW-1:0] s_axil_rdata_o,
   output logic [1:0] s_axil_rresp_o,
   // Raw peripheral flags
   input wire logic flag_cmp0_i,
   input wire logic flag_cmp1_i,
   input wire logic flag_ext0_i,
   input wire logic flag_t0_cmp_i,
   input wire logic flag_t0_ovf_i,
   input wire logic flag_t1_cmpb_i,
   input wire logic flag_t1_ovf_i,
   input wire logic flag_t1_capt_i,
   // Converter core side
   output logic [duc_pkg::VAL_W-1:0] dac_value_o,
   output logic converter_enable_o,
   output logic analog_output_pin_enable_o,
   output logic conv_busy_o
);
   import duc_pkg::*;

   logic wr_en;
   logic [AXI_AW-1:0] wr_addr;
   logic [BYTE_W-1:0] wr_data;
   logic wr_hit, rd_hit;
   logic [AXI_AW-1:0] rd_addr;
   logic [AXI_DW-1:0] rd_data;

   logic [BYTE_W-1:0] ctrl_r, ctrl_nxt;
   logic [BYTE_W-1:0] low_r, low_nxt;
   logic [BYTE_W-1:0] high_r, high_nxt;
   logic align_r, align_nxt;
   logic pend_r, pend_nxt;
   logic [VAL_W-1:0] value_r, value_nxt;
   duc_state_t state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic busy_r, busy_nxt;
   logic pin_en_r, pin_en_nxt;

   logic [NUM_TRIG-1:0] flags;
   logic rise_sel, level_sel;
   logic wr_ctrl, wr_low, wr_high;
   logic auto_on, conv_on;
   logic manual_ld, trig_ld, any_ld;
   logic [VAL_W-1:0] load_val;

   // Right adjust: high[1:0] over low; left adjust: high over low[7:6]
   function automatic logic [VAL_W-1:0] map_value(input logic [BYTE_W-1:0] hi,
                                                  input logic [BYTE_W-1:0] lo,
                                                  input logic la);
      logic [VAL_W-1:0] v;
      if (la) begin
         v = {hi, lo[BYTE_W-1 -: 2]};
      end else begin
         v = {hi[1:0], lo};
      end
      return v;
   endfunction : map_value

   duc_axil_slave u_bus (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .s_axil_awvalid_i(s_axil_awvalid_i),
      .s_axil_awready_o(s_axil_awready_o),
      .s_axil_awaddr_i(s_axil_awaddr_i),
      .s_axil_wvalid_i(s_axil_wvalid_i),
      .s_axil_wready_o(s_axil_wready_o),
      .s_axil_wdata_i(s_axil_wdata_i),
      .s_axil_wstrb_i(s_axil_wstrb_i),
      .s_axil_bvalid_o(s_axil_bvalid_o),
      .s_axil_bready_i(s_axil_bready_i),
      .s_axil_bresp_o(s_axil_bresp_o),
      .s_axil_arvalid_i(s_axil_arvalid_i),
      .s_axil_arready_o(s_axil_arready_o),
      .s_axil_araddr_i(s_axil_araddr_i),
      .s_axil_rvalid_o(s_axil_rvalid_o),
      .s_axil_rready_i(s_axil_rready_i),
      .s_axil_rdata_o(s_axil_rdata_o),
      .s_axil_rresp_o(s_axil_rresp_o),
      .wr_en_o(wr_en),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_hit_i(wr_hit),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .rd_hit_i(rd_hit)
   );

   // Flag order follows the select encoding
   always_comb begin
      flags = '0;
      flags[TRG_CMP0] = flag_cmp0_i;
      flags[TRG_CMP1] = flag_cmp1_i;
      flags[TRG_EXT0] = flag_ext0_i;
      flags[TRG_T0_CMP] = flag_t0_cmp_i;
      flags[TRG_T0_OVF] = flag_t0_ovf_i;
      flags[TRG_T1_CMPB] = flag_t1_cmpb_i;
      flags[TRG_T1_OVF] = flag_t1_ovf_i;
      flags[TRG_T1_CAPT] = flag_t1_capt_i;
   end

   duc_trig_edge u_trig (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .flags_i(flags),
      .sel_i(ctrl_r[CTRL_TS_MSB:CTRL_TS_LSB]),
      .rise_o(rise_sel),
      .level_o(level_sel)
   );

   // Address decode
   assign wr_hit = (wr_addr == OFF_CTRL) || (wr_addr == OFF_VAL_LOW) ||
                   (wr_addr == OFF_VAL_HIGH);
   assign wr_ctrl = wr_en && (wr_addr == OFF_CTRL);
   assign wr_low = wr_en && (wr_addr == OFF_VAL_LOW);
   assign wr_high = wr_en && (wr_addr == OFF_VAL_HIGH);

   always_comb begin
      rd_hit = 1'b1;
      rd_data = WORD_ZERO;
      case (rd_addr)
         OFF_CTRL: rd_data[BYTE_W-1:0] = ctrl_r;
         OFF_VAL_LOW: rd_data[BYTE_W-1:0] = low_r;
         OFF_VAL_HIGH: rd_data[BYTE_W-1:0] = high_r;
         OFF_STATUS: begin
            rd_data[VAL_W-1:0] = value_r;
            rd_data[STS_BUSY_BIT] = busy_r;
            rd_data[STS_PEND_BIT] = pend_r;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // Load decisions
   assign auto_on = ctrl_r[CTRL_ATE_BIT];
   assign conv_on = ctrl_r[CTRL_EN_BIT];
   assign manual_ld = wr_high && !auto_on;
   assign trig_ld = auto_on && rise_sel && (state_r == DUC_IDLE);
   assign any_ld = manual_ld || trig_ld;
   // A manual load takes the byte being written and the adjust bit of now
   assign load_val = manual_ld ? map_value(wr_data, low_r, ctrl_r[CTRL_LA_BIT]) :
                                 map_value(high_r, low_r, align_r);

   // Register file and shadow value
   always_comb begin
      ctrl_nxt = ctrl_r;
      low_nxt = low_r;
      high_nxt = high_r;
      align_nxt = align_r;
      pend_nxt = pend_r;
      value_nxt = value_r;
      if (wr_ctrl) begin
         ctrl_nxt = wr_data & CTRL_WMASK;
      end
      if (wr_low) begin
         low_nxt = wr_data;
         pend_nxt = 1'b1;
      end
      if (wr_high) begin
         high_nxt = wr_data;
         align_nxt = ctrl_r[CTRL_LA_BIT];
      end
      if (any_ld) begin
         value_nxt = load_val;
         // A low write in the load cycle was not used, so it stays pending
         pend_nxt = wr_low;
      end
      pin_en_nxt = conv_on && ctrl_r[CTRL_OE_BIT];
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_r <= BYTE_RST;
         low_r <= BYTE_RST;
         high_r <= BYTE_RST;
         align_r <= 1'b0;
         pend_r <= 1'b0;
         value_r <= VAL_RST;
         pin_en_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         low_r <= low_nxt;
         high_r <= high_nxt;
         align_r <= align_nxt;
         pend_r <= pend_nxt;
         value_r <= value_nxt;
         pin_en_r <= pin_en_nxt;
      end
   end

   // Conversion timer; disabling the converter aborts it
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         DUC_IDLE: begin
            if (any_ld && conv_on) begin
               state_nxt = DUC_CONV;
               cnt_nxt = CNT_W'(CONV_CYCLES - 1);
            end
         end
         DUC_CONV: begin
            if (!conv_on) begin
               state_nxt = DUC_IDLE;
            end else if (manual_ld) begin
               cnt_nxt = CNT_W'(CONV_CYCLES - 1);
            end else if (cnt_r == '0) begin
               state_nxt = DUC_IDLE;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         default: state_nxt = DUC_IDLE;
      endcase
      busy_nxt = (state_nxt == DUC_CONV);
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= DUC_IDLE;
         cnt_r <= '0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign dac_value_o = value_r;
   assign converter_enable_o = ctrl_r[CTRL_EN_BIT];
   assign analog_output_pin_enable_o = pin_en_r;
   assign conv_busy_o = busy_r;

   // Checks
   a_busy_holds:
   assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(busy_r) |-> (busy_r || !conv_on)[*8])
      else $error("conversion ended too early");

   a_manual_load:
   assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_high && !auto_on) |=>
      (value_r == $past(map_value(wr_data, low_r, ctrl_r[CTRL_LA_BIT]))))
      else $error("manual high write did not update value");

   a_auto_gate:
   assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (!auto_on && !wr_high) |=> $stable(value_r))
      else $error("value changed without auto trigger or high write");

   a_trig_load:
   assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (auto_on && rise_sel && !busy_r) |=> (value_r == map_value($past(high_r),
                                             $past(low_r), $past(align_r))))
      else $error("trigger edge did not load value");

   a_busy_ignore:
   assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (auto_on && busy_r) |=> $stable(value_r))
      else $error("value changed during conversion");

   a_level_no_load:
   assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (auto_on && level_sel && $past(level_sel) && $past(auto_on) &&
       $stable(ctrl_r[CTRL_TS_MSB:CTRL_TS_LSB])) |=> $stable(value_r))
      else $error("held trigger level started a conversion");

   a_reserved_zero:
   assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      wr_ctrl |=> (ctrl_r[CTRL_RSV_BIT] == 1'b0))
      else $error("reserved control bit set");

   a_low_staged:
   assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_low && !trig_ld) |=> ($stable(value_r) && pend_r))
      else $error("low byte write reached the converter");

   a_left_map:
   assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (trig_ld && align_r) |=> (value_r[VAL_W-1 -: BYTE_W] == $past(high_r)))
      else $error("left adjusted mapping wrong");

   a_pin_route:
   assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (ctrl_r[CTRL_OE_BIT] && conv_on) |=> analog_output_pin_enable_o)
      else $error("output pin not enabled");

endmodule : duc_top

//--- design/duc_trig_edge.sv
// Purpose: Rising edge detection on raw peripheral flags and source selection
// Assumes: Flags come from logic on the system clock, no synchronisers needed
// Notes: Each flag keeps its own history so a select change makes no false edge
`timescale 1ns/10ps
module duc_trig_edge (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Flags and selection
   input wire logic [duc_pkg::NUM_TRIG-1:0] flags_i,
   input wire logic [duc_pkg::SEL_W-1:0] sel_i,
   // Result
   output logic rise_o,
   output logic level_o
);
   import duc_pkg::*;

   logic [NUM_TRIG-1:0] prev_r;
   logic [NUM_TRIG-1:0] prev_nxt;
   logic [NUM_TRIG-1:0] rise_vec;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_TRIG; gi++) begin : g_flag
         assign rise_vec[gi] = flags_i[gi] & ~prev_r[gi];
      end
   endgenerate

   always_comb begin
      prev_nxt = flags_i;
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_r <= '0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   assign rise_o = rise_vec[sel_i];
   assign level_o = flags_i[sel_i];

endmodule : duc_trig_edge

//--- include/duc_pkg.sv
// Purpose: Shared constants for the converter update and trigger control block
// Assumes: 32-bit AXI4-Lite register access, 10 MHz system clock
// Notes: Register offsets are byte addresses, one aligned word per register
package duc_pkg;

   // Bus widths
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;
   localparam int BYTE_W = 8;
   localparam int VAL_W = 10;
   localparam int NUM_TRIG = 8;
   localparam int SEL_W = 3;

   // Register offsets
   localparam logic [AXI_AW-1:0] OFF_CTRL = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_VAL_LOW = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_VAL_HIGH = 8'h08;
   localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h0C;

   // Control register layout
   localparam int CTRL_ATE_BIT = 7;
   localparam int CTRL_TS_MSB = 6;
   localparam int CTRL_TS_LSB = 4;
   localparam int CTRL_RSV_BIT = 3;
   localparam int CTRL_LA_BIT = 2;
   localparam int CTRL_OE_BIT = 1;
   localparam int CTRL_EN_BIT = 0;
   localparam logic [BYTE_W-1:0] CTRL_WMASK = 8'hF7;

   // Status register layout
   localparam int STS_BUSY_BIT = 16;
   localparam int STS_PEND_BIT = 17;

   // Reset values
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [VAL_W-1:0] VAL_RST = 10'h000;
   localparam logic [AXI_DW-1:0] WORD_ZERO = 32'h0000_0000;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Trigger source encodings
   localparam logic [SEL_W-1:0] TRG_CMP0 = 3'h0;
   localparam logic [SEL_W-1:0] TRG_CMP1 = 3'h1;
   localparam logic [SEL_W-1:0] TRG_EXT0 = 3'h2;
   localparam logic [SEL_W-1:0] TRG_T0_CMP = 3'h3;
   localparam logic [SEL_W-1:0] TRG_T0_OVF = 3'h4;
   localparam logic [SEL_W-1:0] TRG_T1_CMPB = 3'h5;
   localparam logic [SEL_W-1:0] TRG_T1_OVF = 3'h6;
   localparam logic [SEL_W-1:0] TRG_T1_CAPT = 3'h7;

   // Conversion timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int CONV_TIME_NS = 1000;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;

   typedef enum logic {DUC_IDLE, DUC_CONV} duc_state_t;

endpackage : duc_pkg

//--- test/duc_core_model.sv
// Purpose: Behavioural converter core with its output driver
// Assumes: The core follows the shadow value as a level while enabled
// Notes: An undriven pin shows the inverse of the last driven level
`timescale 1ns/10ps
module duc_core_model (
   // Clock
   input wire logic clk_sys_i,
   // Core side
   input wire logic [duc_pkg::VAL_W-1:0] value_i,
   input wire logic enable_i,
   input wire logic pin_enable_i,
   // Output pin
   output logic [duc_pkg::VAL_W-1:0] pin_o
);
   import duc_pkg::*;
   logic [VAL_W-1:0] last_r = VAL_RST;
   always_ff @(posedge clk_sys_i) begin
      if (enable_i && pin_enable_i) begin
         last_r <= value_i;
      end
   end
   // Pin follows the value only while both enables are set
   always_comb begin
      if (enable_i && pin_enable_i) begin
         pin_o = value_i;
      end else begin
         pin_o = ~last_r;
      end
   end
endmodule : duc_core_model

//--- test/duc_tb_top.sv
// Purpose: Self-checking bench for the converter update and trigger control
// Assumes: Register access over AXI4-Lite, flags driven on the system clock
// Notes: A small reference model tracks stored bytes and the shadow value
`timescale 1ns/10ps
module duc_tb_top;
   import duc_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00, flg = 8'h00, ctl = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rd;
   logic awr, wr, bv, arr, rv, en, pe, busy;
   logic [1:0] br, rr;
   logic [9:0] dv, pin, ev;
   int miscompares = 0, check_count = 0;
   int lo = 0, hi = 0, la = 0;
   always #50 clk_sys_i = ~clk_sys_i;

   duc_top i_duc_top (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .s_axil_awvalid_i(awv), .s_axil_awready_o(awr), .s_axil_awaddr_i(awa),
      .s_axil_wvalid_i(wv), .s_axil_wready_o(wr), .s_axil_wdata_i(wd),
      .s_axil_wstrb_i(4'hF), .s_axil_bvalid_o(bv), .s_axil_bready_i(bry),
      .s_axil_bresp_o(br), .s_axil_arvalid_i(arv), .s_axil_arready_o(arr),
      .s_axil_araddr_i(ara), .s_axil_rvalid_o(rv), .s_axil_rready_i(rry),
      .s_axil_rdata_o(rd), .s_axil_rresp_o(rr),
      .flag_cmp0_i(flg[0]), .flag_cmp1_i(flg[1]), .flag_ext0_i(flg[2]),
      .flag_t0_cmp_i(flg[3]), .flag_t0_ovf_i(flg[4]), .flag_t1_cmpb_i(flg[5]),
      .flag_t1_ovf_i(flg[6]), .flag_t1_capt_i(flg[7]), .dac_value_o(dv),
      .converter_enable_o(en), .analog_output_pin_enable_o(pe), .conv_busy_o(busy));
   duc_core_model i_duc_core_model (.clk_sys_i(clk_sys_i), .value_i(dv),
      .enable_i(en), .pin_enable_i(pe), .pin_o(pin));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic conclude;
      $display("comparisons %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk_sys_i);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      bry <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys_i);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
         if (bv) break;
      end
      bry <= 1'b0;
      if (n == 40) begin
         chk("write wait", 1, 0);
         conclude();
      end
      chk("bresp", 32'(er), 32'(br));
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge clk_sys_i);
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys_i);
         if (arv && arr) arv <= 1'b0;
         if (rv) break;
      end
      rry <= 1'b0;
      if (n == 40) begin
         chk("read wait", 1, 0);
         conclude();
      end
      chk("rdata", ed, rd);
      chk("rresp", 32'(er), 32'(rr));
   endtask : axr

   // Reference model of the byte staging and shadow load
   function automatic logic [9:0] map_val(input int h, input int l, input int a);
      return (a != 0) ? {h[7:0], l[7:6]} : {h[1:0], l[7:0]};
   endfunction : map_val

   task automatic wctl(input logic [7:0] c);
      axw(OFF_CTRL, {24'h00_0000, c}, RESP_OKAY);
      ctl = c;
   endtask : wctl

   task automatic wlo(input logic [31:0] v);
      axw(OFF_VAL_LOW, v, RESP_OKAY);
      lo = int'(v[7:0]);
   endtask : wlo

   task automatic whi(input logic [31:0] v);
      axw(OFF_VAL_HIGH, v, RESP_OKAY);
      hi = int'(v[7:0]);
      la = int'(ctl[CTRL_LA_BIT]);
      if (!ctl[CTRL_ATE_BIT]) ev = map_val(hi, lo, la);
   endtask : whi

   initial begin
      int s;
      int k;
      ev = VAL_RST;
      s = $urandom(34);
      repeat (5) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      chk("value reset", 0, 32'(dv));
      axr(OFF_CTRL, 0, RESP_OKAY);
      wctl(8'hFF);
      axr(OFF_CTRL, 32'h0000_00F7, RESP_OKAY);
      axr(8'h40, 0, RESP_SLVERR);
      axw(8'h40, 32'h0000_00FF, RESP_SLVERR);
      axw(OFF_STATUS, 32'h0003_03FF, RESP_SLVERR);
      axr(OFF_STATUS, 0, RESP_OKAY);
      // Manual mode, both adjust settings
      for (k = 0; k < 4; k++) begin
         wctl({5'b0_0000, k[0], 2'b11});
         wlo($urandom);
         chk("low staged", 32'(ev), 32'(dv));
         whi($urandom);
         chk("manual value", 32'(ev), 32'(dv));
         chk("pin", 32'(ev), 32'(pin));
         chk("busy manual", 1, 32'(busy));
      end
      // Auto mode, every trigger source, adjust alternating
      for (s = 0; s < 8; s++) begin
         wctl({1'b1, s[2:0], 1'b0, s[0], 2'b01});
         axr(OFF_CTRL, {24'h00_0000, ctl}, RESP_OKAY);
         wlo($urandom);
         whi($urandom);
         chk("auto hold", 32'(ev), 32'(dv));
         chk("pin off", 0, 32'(pe));
         flg <= ~(8'h01 << s);
         repeat (3) @(posedge clk_sys_i);
         chk("other flags", 32'(ev), 32'(dv));
         flg[s] <= 1'b1;
         ev = map_val(hi, lo, la);
         repeat (3) @(posedge clk_sys_i);
         chk("trig value", 32'(ev), 32'(dv));
         chk("trig busy", 1, 32'(busy));
         axr(OFF_STATUS, (32'h1 << STS_BUSY_BIT) | 32'(ev), RESP_OKAY);
         flg[s] <= 1'b0;
         @(posedge clk_sys_i);
         flg[s] <= 1'b1;
         repeat (10) @(posedge clk_sys_i);
         chk("edge in busy", 0, 32'(busy));
         wlo($urandom);
         whi($urandom);
         repeat (3) @(posedge clk_sys_i);
         chk("flag held", 32'(ev), 32'(dv));
         axr(OFF_STATUS, (32'h1 << STS_PEND_BIT) | 32'(ev), RESP_OKAY);
         flg <= 8'h00;
         @(posedge clk_sys_i);
         flg[s] <= 1'b1;
         ev = map_val(hi, lo, la);
         repeat (3) @(posedge clk_sys_i);
         chk("retrigger", 32'(ev), 32'(dv));
         flg <= 8'h00;
         repeat (12) @(posedge clk_sys_i);
      end
      wctl(8'h00);
      chk("enable off", 0, 32'(en));
      conclude();
   end
endmodule : duc_tb_top
